// ---- include/avpc_pkg.sv ----
// Constants for the ADC volume and input amplifier control slice
// Notes on behaviour
// - Decimator enable starts volume at -95.625 dB, ramping to register.
// - Each volume step during a ramp lasts 16 sample periods.
// - Volume code: 256 steps of 0.375 dB; 0x00 is 0 dB, 0xFF -95.625 dB.
// - Register 0x21 drives channel 2 volume, 0x22 channel 3; both reset zero.
// - Registers 0x23, 0x24, 0x25 control amplifiers 0, 1, 2; reset 0x40.
// - Bit 7 clear: line input, amplifier powered down.
// - Bit 7 set: microphone input, amplifier powered up with gain slewing.
// - Mute bit 6 resets set; while set the gain field is ignored.
// - Gain bits 5:0 in 0.75 dB steps from -12 dB; reset zero.
// - Bit 7 set: amplifier path inverts signal polarity; downstream accounts for it.
// - Channel fully on only when ADC enable and decimator enable both set.
`default_nettype none
package avpc_pkg;
  localparam logic [7:0] ADDR_CH2_VOLUME  = 8'h21;
  localparam logic [7:0] ADDR_CH3_VOLUME  = 8'h22;
  localparam logic [7:0] ADDR_AMP0_CTRL   = 8'h23;
  localparam logic [7:0] ADDR_AMP1_CTRL   = 8'h24;
  localparam logic [7:0] ADDR_AMP2_CTRL   = 8'h25;
  localparam logic [7:0] RST_VOLUME       = 8'h00;
  localparam logic [7:0] RST_AMP_CTRL     = 8'h40;
  localparam logic [7:0] VOL_FULL_ATTEN   = 8'hFF;
  localparam int         AMP_MIC_BIT      = 7;
  localparam int         AMP_MUTE_BIT     = 6;
  localparam int         AMP_GAIN_MSB     = 5;
  localparam logic [5:0] GAIN_MUTED_CODE  = 6'h00;
  localparam int         STEP_PERIODS     = 16;
  localparam logic [4:0] STEP_LAST        = 5'(STEP_PERIODS - 1);
  typedef enum logic [1:0] {AVPC_IDLE, AVPC_RAMP, AVPC_HOLD} avpc_ramp_t;
endpackage
`default_nettype wire

// ---- include/avpc_ramp_if.sv ----
// Interface between the register bank and a volume ramp channel
`timescale 1ns/10ps
`default_nettype none
interface avpc_ramp_if;
  logic       enable;
  logic [7:0] target;
  logic [7:0] level;
  logic       settled;
  modport bank (output enable, output target, input level, input settled);
  modport ramp (input enable, input target, output level, output settled);
endinterface
`default_nettype wire

// ---- rtl/avpc_amp_ctrl.sv ----
// Control decode for one input amplifier
`timescale 1ns/10ps
`default_nettype none
module avpc_amp_ctrl
  import avpc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] ctrl,
  output logic            power_up,
  output logic            mic_mode,
  output logic            slew_en,
  output logic            muted,
  output logic [5:0]      gain,
  output logic            invert
);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_up <= 1'b0;
      mic_mode <= 1'b0;
      slew_en  <= 1'b0;
      muted    <= 1'b1;
      gain     <= 6'h00;
      invert   <= 1'b0;
    end else begin
      power_up <= ctrl[AMP_MIC_BIT];
      mic_mode <= ctrl[AMP_MIC_BIT];
      slew_en  <= ctrl[AMP_MIC_BIT];
      muted    <= ctrl[AMP_MUTE_BIT];
      gain     <= ctrl[AMP_MUTE_BIT] ? GAIN_MUTED_CODE
                                     : ctrl[AMP_GAIN_MSB:0];
      invert   <= ctrl[AMP_MIC_BIT];
    end
  end
endmodule // avpc_amp_ctrl
`default_nettype wire

// ---- rtl/avpc_regs.sv ----
// ADC channel 2/3 volume and input amplifier control registers
`timescale 1ns/10ps
`default_nettype none
module avpc_regs
  import avpc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata,
  input  wire logic       fs_tick,
  input  wire logic       decim_ch2_enable,
  input  wire logic       decim_ch3_enable,
  input  wire logic       adc_ch2_enable,
  input  wire logic       adc_ch3_enable,
  output logic [7:0]      ch2_volume_level,
  output logic [7:0]      ch3_volume_level,
  output logic            ch2_active,
  output logic            ch3_active,
  output logic [2:0]      amp_power_up,
  output logic [2:0]      amp_mic_mode,
  output logic [2:0]      amp_slew_en,
  output logic [2:0]      amp_muted,
  output logic [17:0]     amp_gain,
  output logic [2:0]      amp_invert
);
  import avpc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ch2_volume_code_reg;
  logic [7:0] ch3_volume_code_reg;
  logic [7:0] amp_ctrl_reg [3];
  wire wr_ch2  = reg_write && (reg_addr == ADDR_CH2_VOLUME);
  wire wr_ch3  = reg_write && (reg_addr == ADDR_CH3_VOLUME);
  wire wr_amp0 = reg_write && (reg_addr == ADDR_AMP0_CTRL);
  wire wr_amp1 = reg_write && (reg_addr == ADDR_AMP1_CTRL);
  wire wr_amp2 = reg_write && (reg_addr == ADDR_AMP2_CTRL);
  wire [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == ADDR_CH2_VOLUME) ? ch2_volume_code_reg :
    (reg_addr == ADDR_CH3_VOLUME) ? ch3_volume_code_reg :
    (reg_addr == ADDR_AMP0_CTRL)  ? amp_ctrl_reg[0] :
    (reg_addr == ADDR_AMP1_CTRL)  ? amp_ctrl_reg[1] :
    (reg_addr == ADDR_AMP2_CTRL)  ? amp_ctrl_reg[2] : 8'h00;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ch2_volume_code_reg <= RST_VOLUME;
      ch3_volume_code_reg <= RST_VOLUME;
      amp_ctrl_reg[0]     <= RST_AMP_CTRL;
      amp_ctrl_reg[1]     <= RST_AMP_CTRL;
      amp_ctrl_reg[2]     <= RST_AMP_CTRL;
      reg_rdata           <= 8'h00;
    end else begin
      if (wr_ch2) ch2_volume_code_reg <= reg_wdata;
      if (wr_ch3) ch3_volume_code_reg <= reg_wdata;
      if (wr_amp0) amp_ctrl_reg[0] <= reg_wdata;
      if (wr_amp1) amp_ctrl_reg[1] <= reg_wdata;
      if (wr_amp2) amp_ctrl_reg[2] <= reg_wdata;
      if (reg_read) reg_rdata <= rd_mux;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Volume ramps
  avpc_ramp_if rp2 ();
  avpc_ramp_if rp3 ();
  assign rp2.enable = decim_ch2_enable;
  assign rp3.enable = decim_ch3_enable;
  assign rp2.target = ch2_volume_code_reg;
  assign rp3.target = ch3_volume_code_reg;
  avpc_vol_ramp u_ramp2 (
    .clock   (clock),
    .reset_n (reset_n),
    .fs_tick (fs_tick),
    .rp      (rp2.ramp)
  );
  avpc_vol_ramp u_ramp3 (
    .clock   (clock),
    .reset_n (reset_n),
    .fs_tick (fs_tick),
    .rp      (rp3.ramp)
  );
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ch2_volume_level <= VOL_FULL_ATTEN;
      ch3_volume_level <= VOL_FULL_ATTEN;
      ch2_active       <= 1'b0;
      ch3_active       <= 1'b0;
    end else begin
      ch2_volume_level <= rp2.level;
      ch3_volume_level <= rp3.level;
      ch2_active <= adc_ch2_enable && decim_ch2_enable;
      ch3_active <= adc_ch3_enable && decim_ch3_enable;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Amplifier decode
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_amp
      avpc_amp_ctrl u_amp (
        .clock    (clock),
        .reset_n  (reset_n),
        .ctrl     (amp_ctrl_reg[gi]),
        .power_up (amp_power_up[gi]),
        .mic_mode (amp_mic_mode[gi]),
        .slew_en  (amp_slew_en[gi]),
        .muted    (amp_muted[gi]),
        .gain     (amp_gain[gi*6 +: 6]),
        .invert   (amp_invert[gi])
      );
    end
  endgenerate
endmodule // avpc_regs
`default_nettype wire

// ---- rtl/avpc_vol_ramp.sv ----
// Volume ramp for one decimator channel
`timescale 1ns/10ps
`default_nettype none
module avpc_vol_ramp
  import avpc_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  reset_n,
  input  wire logic  fs_tick,
  avpc_ramp_if.ramp  rp
);
  avpc_ramp_t state_reg;
  avpc_ramp_t state_next;
  logic [7:0] level_reg;
  logic [4:0] tick_reg;
  wire        at_target = (level_reg == rp.target);
  wire        step_due  = fs_tick && (tick_reg == STEP_LAST);
  wire [7:0]  level_up  = level_reg + 8'h01;
  wire [7:0]  level_dn  = level_reg - 8'h01;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AVPC_IDLE: if (rp.enable) state_next = AVPC_RAMP;
      AVPC_RAMP: if (!rp.enable) state_next = AVPC_IDLE;
                 else if (at_target) state_next = AVPC_HOLD;
      AVPC_HOLD: if (!rp.enable) state_next = AVPC_IDLE;
                 else if (!at_target) state_next = AVPC_RAMP;
      default:   state_next = AVPC_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= AVPC_IDLE;
      level_reg <= VOL_FULL_ATTEN;
      tick_reg  <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == AVPC_IDLE) begin
        level_reg <= VOL_FULL_ATTEN;
        tick_reg  <= 5'h00;
      end else if (state_reg == AVPC_RAMP) begin
        if (fs_tick) tick_reg <= step_due ? 5'h00 : tick_reg + 5'h01;
        if (step_due && !at_target)
          level_reg <= (level_reg > rp.target) ? level_dn : level_up;
      end else begin
        tick_reg <= 5'h00;
      end
    end
  end
  assign rp.level   = level_reg;
  assign rp.settled = (state_reg == AVPC_HOLD);
endmodule // avpc_vol_ramp
`default_nettype wire

// ---- tb/avpc_regs_chk.sv ----
// Port assertions for the volume and amplifier register slice
`timescale 1ns/10ps
`default_nettype none
module avpc_regs_chk
  import avpc_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        decim_ch2_enable,
  input wire logic        adc_ch2_enable,
  input wire logic [7:0]  ch2_volume_level,
  input wire logic        ch2_active,
  input wire logic [2:0]  amp_power_up,
  input wire logic [2:0]  amp_mic_mode,
  input wire logic [2:0]  amp_slew_en,
  input wire logic [2:0]  amp_muted,
  input wire logic [17:0] amp_gain,
  input wire logic [2:0]  amp_invert
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_wr0;
    reg_write && reg_addr == ADDR_AMP0_CTRL ##1 !reg_write;
  endsequence
  sequence s_both;
    (adc_ch2_enable && decim_ch2_enable) [*2];
  endsequence
  a_amp_write: assert property (
    s_wr0 |=> amp_muted[0] == $past(reg_wdata[6], 2)
      && amp_power_up[0] == $past(reg_wdata[7], 2))
    else $error("amp0 decode");
  a_mute_gain: assert property (
    amp_muted[0] |-> amp_gain[5:0] == GAIN_MUTED_CODE)
    else $error("muted gain");
  a_mic_power: assert property (
    amp_mic_mode == amp_power_up) else $error("mic vs power");
  a_slew_power: assert property (
    amp_slew_en == amp_power_up) else $error("slew vs power");
  a_invert_amp: assert property (
    amp_invert == amp_power_up) else $error("invert flag");
  a_active_both: assert property (
    s_both |-> ch2_active) else $error("channel not active");
  a_active_off: assert property (
    (!decim_ch2_enable) [*2] |-> !ch2_active) else $error("channel active");
  a_ramp_start: assert property (
    $rose(decim_ch2_enable) |-> ##2 ch2_volume_level == VOL_FULL_ATTEN)
    else $error("ramp start level");
  a_step_one: assert property (
    decim_ch2_enable && $past(decim_ch2_enable, 2)
      && $changed(ch2_volume_level)
    |-> 8'(ch2_volume_level - $past(ch2_volume_level)) inside {8'h01, 8'hFF})
    else $error("volume jump");
  a_unmapped_rd: assert property (
    reg_read && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
    else $error("unmapped");
endmodule // avpc_regs_chk
bind avpc_regs avpc_regs_chk u_chk (.clock, .reset_n, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .decim_ch2_enable, .adc_ch2_enable,
  .ch2_volume_level, .ch2_active, .amp_power_up, .amp_mic_mode, .amp_slew_en,
  .amp_muted, .amp_gain, .amp_invert);
`default_nettype wire

// ---- tb/avpc_regs_tb.sv ----
// Self-checking bench for the volume and amplifier register slice
`timescale 1ns/10ps
`default_nettype none
module avpc_regs_tb;
  import avpc_pkg::*;
  typedef struct {logic [7:0] a, r, d, e;} avpc_row_t;
  avpc_row_t rows [6] = '{'{8'h21, 8'h00, 8'hA5, 8'hA5},
    '{8'h22, 8'h00, 8'h5A, 8'h5A}, '{8'h23, 8'h40, 8'hFF, 8'hFF},
    '{8'h24, 8'h40, 8'h00, 8'h00}, '{8'h25, 8'h40, 8'h90, 8'h90},
    '{8'h30, 8'h00, 8'h55, 8'h00}};
  logic clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, fs_tick = 0;
  logic decim_ch2_enable = 0, decim_ch3_enable = 0;
  logic adc_ch2_enable = 0, adc_ch3_enable = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, q;
  wire logic [7:0] reg_rdata, ch2_volume_level, ch3_volume_level;
  wire logic ch2_active, ch3_active;
  wire logic [2:0] amp_power_up, amp_mic_mode, amp_slew_en, amp_muted;
  wire logic [2:0] amp_invert;
  wire logic [17:0] amp_gain;
  int err_total = 0, checks = 0, cyc = 0;
  avpc_regs dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .fs_tick, .decim_ch2_enable, .decim_ch3_enable,
    .adc_ch2_enable, .adc_ch3_enable, .ch2_volume_level, .ch3_volume_level,
    .ch2_active, .ch3_active, .amp_power_up, .amp_mic_mode, .amp_slew_en,
    .amp_muted, .amp_gain, .amp_invert);
  always #10 clock = ~clock;
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task cmp(input logic [17:0] g, e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge clock) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
    @(negedge clock) reg_write = 0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] r);
    @(negedge clock) {reg_addr, reg_read} = {a, 1'b1};
    @(negedge clock) reg_read = 0;
    r = reg_rdata;
  endtask
  // Pulses ticks until the level lands on the target, counting them
  task ramp(input logic ch, input logic [7:0] t, input int n);
    int k;
    k = 0;
    while ((ch ? ch3_volume_level : ch2_volume_level) !== t && k < 300) begin
      @(negedge clock) fs_tick = 1;
      @(negedge clock) fs_tick = 0;
      repeat (2) @(negedge clock);
      k++;
    end
    cmp(18'(k), 18'(n));
  endtask
  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1;
    cmp(amp_muted, 3'b111);
    cmp(ch3_volume_level, VOL_FULL_ATTEN);
    foreach (rows[i]) begin
      rd(rows[i].a, q);
      cmp(q, rows[i].r);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      cmp(q, rows[i].e);
    end
    $display("test registers done");
    cmp(amp_power_up, 3'b101);
    cmp(amp_mic_mode, 3'b101);
    cmp(amp_slew_en, 3'b101);
    cmp(amp_muted, 3'b001);
    cmp(amp_gain, {6'h10, 12'h000});
    cmp(amp_invert, 3'b101);
    $display("test amplifiers done");
    wr(8'h21, 8'hFC);
    @(negedge clock) {adc_ch2_enable, decim_ch2_enable} = 2'b11;
    repeat (3) @(negedge clock);
    cmp(ch2_active, 1'b1);
    cmp(ch2_volume_level, VOL_FULL_ATTEN);
    ramp(1'b0, 8'hFC, 48);
    wr(8'h21, 8'hFE);
    ramp(1'b0, 8'hFE, 32);
    cmp(ch3_volume_level, VOL_FULL_ATTEN);
    @(negedge clock) decim_ch2_enable = 0;
    repeat (3) @(negedge clock);
    cmp(ch2_active, 1'b0);
    cmp(ch2_volume_level, VOL_FULL_ATTEN);
    $display("test ramp done");
    wr(8'h22, 8'hFD);
    @(negedge clock) decim_ch3_enable = 1;
    repeat (3) @(negedge clock);
    cmp(ch3_active, 1'b0);
    @(negedge clock) adc_ch3_enable = 1;
    repeat (3) @(negedge clock);
    cmp(ch3_active, 1'b1);
    cmp(ch3_volume_level, VOL_FULL_ATTEN);
    ramp(1'b1, 8'hFD, 32);
    cmp(ch2_volume_level, VOL_FULL_ATTEN);
    @(negedge clock) {adc_ch3_enable, decim_ch3_enable} = 2'b00;
    repeat (3) @(negedge clock);
    cmp(ch3_active, 1'b0);
    cmp(ch3_volume_level, VOL_FULL_ATTEN);
    $display("test channel 3 done");
    @(negedge clock) reset_n = 0;
    @(negedge clock) reset_n = 1;
    cmp(amp_muted, 3'b111);
    rd(8'h21, q);
    cmp(q, 8'h00);
    $display("test second reset done");
    end_of_test();
  end
endmodule // avpc_regs_tb
`default_nettype wire
